// [hw/clsl_pkg.sv]
// Notes on behaviour
// - Data block carries CRC16; card checks it.
// - Clear mode ignores lock bit; match zeroes secret.
// - Password mismatch in clear/lock/unlock sets failure flag.
// - Lock with matching password locks card, sets flag.
// - Set-password plus lock bit stores, and locks unless new password is empty.
// - Nonzero stored length locks card at power-up.
// - Lock when locked/no password, unlock when unlocked fail.
// - Unlock with matching password clears locked flag.
// - Unlock lasts one power session only.
// - Erase bit with other bits is rejected, fails.
// - Accepted erase wipes content, secret, unlocks card.
// - Forced erase on unlocked card fails.
// - Status word describes previous command in responses.
// - Execution flags held until host reads status.
// - Clearing classes: read, next command, current state.
// - Bits 31..28 range, address, length, erase-sequence errors.
// - Bits 27, 26 erase parameter, write-protect violation.
// - Bit 25 locked state; bit 24 lock failure.
// - Bits 23, 22 command CRC, illegal command.
// - Bits 21..19 ECC, controller, general errors.
// - Mode byte layout, then length, then password.
// - Replacement sends old then new; old must match.
package clsl_pkg;
    localparam int CLSL_MAX_SECRET = 16;
    localparam int CLSL_BUF_BYTES = 2 + 2 * CLSL_MAX_SECRET;
    localparam int CLSL_SECRET_W = 8 * CLSL_MAX_SECRET;
    localparam int CLSL_BLEN_W = 10;
    // Mode byte fields.
    localparam int CLSL_MODE_SET = 0;
    localparam int CLSL_MODE_CLR = 1;
    localparam int CLSL_MODE_LOCK = 2;
    localparam int CLSL_MODE_ERASE = 3;
    localparam logic [7:0] CLSL_ERASE_ONLY = 8'h08;
    // Status word bit positions.
    localparam int CLSL_ST_RANGE = 31;
    localparam int CLSL_ST_ADDR = 30;
    localparam int CLSL_ST_BLEN = 29;
    localparam int CLSL_ST_ESEQ = 28;
    localparam int CLSL_ST_EPARAM = 27;
    localparam int CLSL_ST_WP = 26;
    localparam int CLSL_ST_LOCKED = 25;
    localparam int CLSL_ST_LFAIL = 24;
    localparam int CLSL_ST_CRC = 23;
    localparam int CLSL_ST_ILLEGAL = 22;
    localparam int CLSL_ST_ECC = 21;
    localparam int CLSL_ST_CC = 20;
    localparam int CLSL_ST_GEN = 19;
    localparam int CLSL_ST_LOW_W = 19;
    localparam logic [15:0] CLSL_CRC_POLY = 16'h1021;
    localparam logic [15:0] CLSL_CRC_INIT = 16'h0000;
    localparam logic [31:0] CLSL_STATUS_RESET = 32'h0000_0000;
    typedef enum logic [5:0] {
        CLSL_IDLE = 6'b000001,
        CLSL_START = 6'b000010,
        CLSL_DATA = 6'b000100,
        CLSL_CRC = 6'b001000,
        CLSL_STOP = 6'b010000,
        CLSL_EXEC = 6'b100000
    } clsl_state_e;
endpackage

// [hw/clsl_card_lock_status.sv]
`timescale 1ns/100ps
module clsl_card_lock_status (
    input wire logic clk,
    input wire logic srst,
    input wire logic card_clk,
    input wire logic dat_in,
    input wire logic lock_cmd,
    input wire logic [clsl_pkg::CLSL_BLEN_W-1:0] block_len,
    input wire logic cmd_received,
    input wire logic cmd_crc_bad,
    input wire logic cmd_illegal,
    input wire logic status_read,
    input wire logic data_access_req,
    input wire logic ev_out_of_range,
    input wire logic ev_address_error,
    input wire logic ev_block_len_error,
    input wire logic ev_erase_seq_error,
    input wire logic ev_erase_param,
    input wire logic ev_wp_violation,
    input wire logic ev_ecc_failed,
    input wire logic ev_internal_controller_error,
    input wire logic ev_general_error,
    input wire logic [7:0] nv_len_in,
    input wire logic [clsl_pkg::CLSL_SECRET_W-1:0] nv_secret_in,
    output logic nv_we,
    output logic [7:0] nv_len_out,
    output logic [clsl_pkg::CLSL_SECRET_W-1:0] nv_secret_out,
    output logic erase_all,
    output logic blk_crc_fail,
    output logic lock_busy,
    output logic locked_flag,
    output logic data_access_ok,
    output logic [31:0] card_status_word
);
    import clsl_pkg::*;

    clsl_state_e state_r;
    logic [2:0] clk_sync_r;
    logic [1:0] dat_sync_r;
    logic card_rise;
    logic [7:0] buf_r [0:CLSL_BUF_BYTES-1];
    logic [7:0] shift_r;
    logic [2:0] bit_cnt_r;
    logic [CLSL_BLEN_W-1:0] byte_cnt_r;
    logic [CLSL_BLEN_W-1:0] blen_r;
    logic [15:0] crc_r;
    logic [15:0] crc_rx_r;
    logic [3:0] crc_cnt_r;
    logic [7:0] stored_secret_length;
    logic [7:0] stored_secret [0:CLSL_MAX_SECRET-1];
    logic load_pend_r;
    logic locked_r;
    logic [8:0] c_flags_r;
    logic [1:0] b_flags_r;
    logic exec_fail;
    logic exec_lock;
    logic exec_unlock;
    logic exec_store;
    logic exec_wipe;
    logic exec_blen_err;
    logic [7:0] new_len;
    logic [7:0] mode;
    logic [7:0] sent_len;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic b);
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CLSL_CRC_POLY : 16'h0000);
    endfunction

    // True when the first len bytes of the password field equal the secret.
    function automatic logic old_matches(input logic [7:0] len);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < CLSL_MAX_SECRET; i++) begin
            if (8'(i) < len && buf_r[i + 2] != stored_secret[i]) begin
                ok = 1'b0;
            end
        end
        old_matches = ok;
    endfunction

    // The first stage of each synchroniser feeds only the second stage.
    always_ff @(posedge clk) begin
        if (srst) begin
            clk_sync_r <= 3'h0;
            dat_sync_r <= 2'h0;
        end else begin
            clk_sync_r <= {clk_sync_r[1:0], card_clk};
            dat_sync_r <= {dat_sync_r[0], dat_in};
        end
    end
    assign card_rise = clk_sync_r[1] & ~clk_sync_r[2];

    // Receiver for the lock/unlock data block: start bit, bytes MSB first,
    // 16 CRC bits and a stop bit, each taken on a card clock rise.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= CLSL_IDLE;
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= '0;
            blen_r <= '0;
            shift_r <= 8'h00;
            crc_r <= CLSL_CRC_INIT;
            crc_rx_r <= 16'h0000;
            crc_cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                CLSL_IDLE: begin
                    if (lock_cmd && !load_pend_r && block_len != '0 &&
                        block_len <= CLSL_BLEN_W'(CLSL_BUF_BYTES)) begin
                        state_r <= CLSL_START;
                        blen_r <= block_len;
                    end
                end
                CLSL_START: begin
                    if (card_rise && !dat_sync_r[1]) begin
                        state_r <= CLSL_DATA;
                        bit_cnt_r <= 3'h0;
                        byte_cnt_r <= '0;
                        crc_r <= CLSL_CRC_INIT;
                    end
                end
                CLSL_DATA: begin
                    if (card_rise) begin
                        shift_r <= {shift_r[6:0], dat_sync_r[1]};
                        crc_r <= crc_step(crc_r, dat_sync_r[1]);
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            byte_cnt_r <= byte_cnt_r + 1'b1;
                            if (byte_cnt_r + 1'b1 == blen_r) begin
                                state_r <= CLSL_CRC;
                                crc_cnt_r <= 4'h0;
                            end
                        end
                    end
                end
                CLSL_CRC: begin
                    if (card_rise) begin
                        crc_rx_r <= {crc_rx_r[14:0], dat_sync_r[1]};
                        crc_cnt_r <= crc_cnt_r + 4'h1;
                        if (crc_cnt_r == 4'hf) begin
                            state_r <= CLSL_STOP;
                        end
                    end
                end
                CLSL_STOP: begin
                    if (card_rise) begin
                        state_r <= CLSL_EXEC;
                    end
                end
                CLSL_EXEC: begin
                    state_r <= CLSL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (state_r == CLSL_DATA && card_rise && bit_cnt_r == 3'h7) begin
            buf_r[byte_cnt_r[5:0]] <= {shift_r[6:0], dat_sync_r[1]};
        end
    end

    assign mode = buf_r[0];
    assign sent_len = buf_r[1];
    assign new_len = 8'(sent_len - stored_secret_length);

    // Command decode, done in the cycle after the stop bit.
    always_comb begin
        exec_fail = 1'b0;
        exec_lock = 1'b0;
        exec_unlock = 1'b0;
        exec_store = 1'b0;
        exec_wipe = 1'b0;
        exec_blen_err = 1'b0;
        if (state_r == CLSL_EXEC && crc_r == crc_rx_r) begin
            if (mode[CLSL_MODE_ERASE]) begin
                if (mode != CLSL_ERASE_ONLY) begin
                    exec_fail = 1'b1;
                end else if (!locked_r) begin
                    exec_fail = 1'b1;
                end else begin
                    exec_wipe = 1'b1;
                end
            end else if (blen_r != CLSL_BLEN_W'(sent_len) + 2'd2) begin
                exec_blen_err = 1'b1;
                exec_fail = 1'b1;
            end else if (mode[CLSL_MODE_CLR]) begin
                // The lock bit is a don't-care here.
                if (sent_len == stored_secret_length &&
                    old_matches(stored_secret_length)) begin
                    exec_store = 1'b1;
                end else begin
                    exec_fail = 1'b1;
                end
            end else if (mode[CLSL_MODE_SET]) begin
                if (sent_len >= stored_secret_length &&
                    new_len <= 8'(CLSL_MAX_SECRET) &&
                    old_matches(stored_secret_length)) begin
                    exec_store = 1'b1;
                    exec_lock = mode[CLSL_MODE_LOCK] && new_len != 8'h00;
                end else begin
                    exec_fail = 1'b1;
                end
            end else if (mode[CLSL_MODE_LOCK]) begin
                if (locked_r || stored_secret_length == 8'h00) begin
                    exec_fail = 1'b1;
                end else if (sent_len == stored_secret_length &&
                             old_matches(stored_secret_length)) begin
                    exec_lock = 1'b1;
                end else begin
                    exec_fail = 1'b1;
                end
            end else begin
                if (!locked_r) begin
                    exec_fail = 1'b1;
                end else if (sent_len == stored_secret_length &&
                             old_matches(stored_secret_length)) begin
                    exec_unlock = 1'b1;
                end else begin
                    exec_fail = 1'b1;
                end
            end
        end
    end

    // The secret mirror is refilled from non-volatile storage after every
    // power-on reset, so an unlock never survives a power cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            load_pend_r <= 1'b1;
            locked_r <= 1'b0;
            stored_secret_length <= 8'h00;
            for (int i = 0; i < CLSL_MAX_SECRET; i++) begin
                stored_secret[i] <= 8'h00;
            end
        end else if (load_pend_r) begin
            load_pend_r <= 1'b0;
            stored_secret_length <= nv_len_in;
            locked_r <= nv_len_in != 8'h00;
            for (int i = 0; i < CLSL_MAX_SECRET; i++) begin
                stored_secret[i] <= nv_secret_in[8 * i +: 8];
            end
        end else begin
            if (exec_wipe) begin
                stored_secret_length <= 8'h00;
                locked_r <= 1'b0;
                for (int i = 0; i < CLSL_MAX_SECRET; i++) begin
                    stored_secret[i] <= 8'h00;
                end
            end else if (exec_store) begin
                // Clear mode leaves new_len at zero, emptying the secret.
                stored_secret_length <= mode[CLSL_MODE_CLR] ? 8'h00 : new_len;
                for (int i = 0; i < CLSL_MAX_SECRET; i++) begin
                    stored_secret[i] <= (!mode[CLSL_MODE_CLR] &&
                        8'(i) < new_len) ?
                        buf_r[i + 2 + int'(stored_secret_length)] : 8'h00;
                end
                if (mode[CLSL_MODE_CLR]) begin
                    locked_r <= 1'b0;
                end
            end
            if (exec_lock) begin
                locked_r <= 1'b1;
            end else if (exec_unlock) begin
                locked_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            nv_we <= 1'b0;
            erase_all <= 1'b0;
            blk_crc_fail <= 1'b0;
        end else begin
            nv_we <= exec_store | exec_wipe;
            erase_all <= exec_wipe;
            blk_crc_fail <= state_r == CLSL_EXEC && crc_r != crc_rx_r;
        end
    end

    always_comb begin
        for (int i = 0; i < CLSL_MAX_SECRET; i++) begin
            nv_secret_out[8 * i +: 8] = stored_secret[i];
        end
    end
    assign nv_len_out = stored_secret_length;

    // Clear-on-read flags: an event in the read cycle survives the clear.
    always_ff @(posedge clk) begin
        if (srst) begin
            c_flags_r <= 9'h000;
        end else begin
            c_flags_r <= (c_flags_r & {9{~status_read}}) | {
                ev_out_of_range,
                ev_address_error,
                ev_block_len_error | exec_blen_err |
                    (lock_cmd && state_r == CLSL_IDLE && (block_len == '0 ||
                    block_len > CLSL_BLEN_W'(CLSL_BUF_BYTES))),
                ev_erase_seq_error,
                ev_erase_param,
                ev_wp_violation,
                exec_fail | (data_access_req & ~data_access_ok),
                ev_ecc_failed,
                ev_internal_controller_error
            };
        end
    end

    // Command-class flags describe the previous command and are replaced
    // when the next command arrives.
    logic gen_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            b_flags_r <= 2'h0;
            gen_r <= 1'b0;
        end else begin
            if (cmd_received) begin
                b_flags_r <= {cmd_crc_bad, cmd_illegal};
            end
            gen_r <= (gen_r & ~status_read) | ev_general_error;
        end
    end

    assign locked_flag = locked_r;
    assign lock_busy = state_r != CLSL_IDLE;
    assign data_access_ok = !locked_r && !load_pend_r;
    assign card_status_word = {
        c_flags_r[8:3],
        locked_r,
        c_flags_r[2],
        b_flags_r,
        c_flags_r[1:0],
        gen_r,
        CLSL_STATUS_RESET[CLSL_ST_LOW_W-1:0]
    };
endmodule

// [verification/clsl_host_model.sv]
`timescale 1ns/100ps
module clsl_host_model (
    input wire logic clk,
    output logic card_clk,
    output logic dat_in
);
    import clsl_pkg::*;
    initial begin
        card_clk = 1'b0;
        dat_in = 1'b1;
    end
    // One bit per 160 ns; data moves only while the link clock is low.
    task automatic put_bit(input logic b);
        dat_in <= b;
        repeat (4) @(posedge clk);
        card_clk <= 1'b1;
        repeat (4) @(posedge clk);
        card_clk <= 1'b0;
    endtask
    task automatic send(input logic [7:0] blk [34], input int n,
                        input logic bad);
        logic [15:0] crc;
        logic fb;
        crc = CLSL_CRC_INIT;
        put_bit(1'b0);
        for (int i = 0; i < n; i++) begin
            for (int j = 7; j >= 0; j--) begin
                fb = crc[15] ^ blk[i][j];
                crc = {crc[14:0], 1'b0} ^ (fb ? CLSL_CRC_POLY : 16'h0000);
                put_bit(blk[i][j]);
            end
        end
        if (bad) begin
            crc = ~crc;
        end
        for (int j = 15; j >= 0; j--) begin
            put_bit(crc[j]);
        end
        put_bit(1'b1);
        // The released line must not keep showing the stop level.
        dat_in <= 1'b0;
    endtask
endmodule

// [verification/clsl_card_lock_status_assertions.sv]
`timescale 1ns/100ps
module clsl_card_lock_status_assertions (
    input wire logic clk,
    input wire logic srst,
    input wire logic cmd_received,
    input wire logic cmd_crc_bad,
    input wire logic cmd_illegal,
    input wire logic status_read,
    input wire logic data_access_req,
    input wire logic lock_cmd,
    input wire logic lock_busy,
    input wire logic ev_out_of_range,
    input wire logic ev_wp_violation,
    input wire logic ev_internal_controller_error,
    input wire logic [7:0] nv_len_in,
    input wire logic [7:0] nv_len_out,
    input wire logic erase_all,
    input wire logic blk_crc_fail,
    input wire logic locked_flag,
    input wire logic data_access_ok,
    input wire logic [31:0] card_status_word
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_power_up;
        $fell(srst);
    endsequence
    sequence s_quiet_read;
        status_read && !lock_busy && !lock_cmd && !data_access_req;
    endsequence
    lock_mirror_a: assert property (
        card_status_word[25] == locked_flag)
        else $error("locked bit differs from flag");
    power_lock_a: assert property (
        s_power_up |=> locked_flag == (nv_len_in != 8'h00))
        else $error("power-up lock wrong");
    crc_bit_a: assert property (
        cmd_received |=> card_status_word[23] == $past(cmd_crc_bad))
        else $error("bit 23 not loaded");
    illegal_bit_a: assert property (
        cmd_received |=> card_status_word[22] == $past(cmd_illegal))
        else $error("bit 22 not loaded");
    range_set_a: assert property (
        ev_out_of_range |=> card_status_word[31])
        else $error("bit 31 not set");
    wp_set_a: assert property (
        ev_wp_violation |=> card_status_word[26])
        else $error("bit 26 not set");
    ctrl_err_a: assert property (
        ev_internal_controller_error |=> card_status_word[20])
        else $error("bit 20 not set");
    fail_hold_a: assert property (
        card_status_word[24] && !status_read |=> card_status_word[24])
        else $error("bit 24 lost");
    fail_clear_a: assert property (
        s_quiet_read |=> !card_status_word[24])
        else $error("bit 24 not cleared");
    erase_wipe_a: assert property (
        erase_all |-> !locked_flag && nv_len_out == 8'h00)
        else $error("erase left state");
    erase_locked_a: assert property (
        erase_all |-> $past(locked_flag))
        else $error("erase while unlocked");
    crc_keep_a: assert property (
        blk_crc_fail |-> !erase_all && $stable(locked_flag))
        else $error("bad block had effect");
    access_gate_a: assert property (
        locked_flag |-> !data_access_ok)
        else $error("access open while locked");
    // The lock may only move after a command or the power-up load.
    lock_change_a: assert property (
        $changed(locked_flag) |-> $past(lock_busy) || $past(srst, 2))
        else $error("locked flag moved without a command");
endmodule
bind clsl_card_lock_status clsl_card_lock_status_assertions i_chk (.clk,
    .srst, .cmd_received, .cmd_crc_bad, .cmd_illegal, .status_read,
    .data_access_req, .lock_cmd, .lock_busy, .ev_out_of_range,
    .ev_wp_violation, .ev_internal_controller_error, .nv_len_in,
    .nv_len_out, .erase_all, .blk_crc_fail, .locked_flag, .data_access_ok,
    .card_status_word);

// [verification/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import clsl_pkg::*;
    typedef struct {
        logic [7:0] md;
        logic [7:0] pl;
        logic [63:0] pay;
        logic lk;
        logic fl;
        logic [7:0] ln;
    } clsl_row_s;
    logic clk, srst, card_clk, dat_in, lock_cmd, cmd_received, cmd_crc_bad;
    logic cmd_illegal, status_read, data_access_req, nv_we, erase_all;
    logic blk_crc_fail, lock_busy, locked_flag, data_access_ok;
    logic crc_seen, erase_seen;
    logic [8:0] ev;
    logic [9:0] block_len;
    logic [7:0] nv_len_in, nv_len_out;
    logic [CLSL_SECRET_W-1:0] nv_secret_in, nv_secret_out;
    logic [31:0] card_status_word;
    int num_errors = 0;
    int cmp_count = 0;
    localparam logic [63:0] PW_OK = 64'h4142_0000_0000_0000;
    localparam logic [63:0] PW_BAD = 64'h4143_0000_0000_0000;
    clsl_row_s rows [15] = '{
        '{8'h04, 8'h00, 64'h0, 1'b0, 1'b1, 8'h00},
        '{8'h00, 8'h00, 64'h0, 1'b0, 1'b1, 8'h00},
        '{8'h01, 8'h02, PW_OK, 1'b0, 1'b0, 8'h02},
        '{8'h04, 8'h02, PW_BAD, 1'b0, 1'b1, 8'h02},
        '{8'h04, 8'h02, PW_OK, 1'b1, 1'b0, 8'h02},
        '{8'h04, 8'h02, PW_OK, 1'b1, 1'b1, 8'h02},
        '{8'h0c, 8'h00, 64'h0, 1'b1, 1'b1, 8'h02},
        '{8'h00, 8'h02, PW_BAD, 1'b1, 1'b1, 8'h02},
        '{8'h00, 8'h02, PW_OK, 1'b0, 1'b0, 8'h02},
        '{8'h08, 8'h00, 64'h0, 1'b0, 1'b1, 8'h02},
        '{8'h05, 8'h04, 64'h4142_4344_0000_0000, 1'b1, 1'b0, 8'h02},
        '{8'h08, 8'h00, 64'h0, 1'b0, 1'b0, 8'h00},
        '{8'h01, 8'h02, PW_OK, 1'b0, 1'b0, 8'h02},
        '{8'h06, 8'h02, PW_BAD, 1'b0, 1'b1, 8'h02},
        '{8'h06, 8'h02, PW_OK, 1'b0, 1'b0, 8'h00}
    };
    clsl_card_lock_status i_dut (.clk, .srst, .card_clk, .dat_in, .lock_cmd,
        .block_len, .cmd_received, .cmd_crc_bad, .cmd_illegal, .status_read,
        .data_access_req, .ev_out_of_range(ev[8]), .ev_address_error(ev[7]),
        .ev_block_len_error(ev[6]), .ev_erase_seq_error(ev[5]),
        .ev_erase_param(ev[4]), .ev_wp_violation(ev[3]),
        .ev_ecc_failed(ev[2]), .ev_internal_controller_error(ev[1]),
        .ev_general_error(ev[0]), .nv_len_in, .nv_secret_in, .nv_we,
        .nv_len_out, .nv_secret_out, .erase_all, .blk_crc_fail, .lock_busy,
        .locked_flag, .data_access_ok, .card_status_word);
    clsl_host_model i_host (.clk, .card_clk, .dat_in);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Storage outlives resets, which is what makes the relock observable.
    always @(posedge clk) begin
        crc_seen <= crc_seen | (blk_crc_fail === 1'b1);
        erase_seen <= erase_seen | (erase_all === 1'b1);
        if (erase_all === 1'b1) begin
            nv_len_in <= 8'h00;
            nv_secret_in <= '0;
        end else if (nv_we === 1'b1) begin
            nv_len_in <= nv_len_out;
            nv_secret_in <= nv_secret_out;
        end
    end
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        @(negedge clk);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reset_dut;
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic pulse_read;
        @(posedge clk);
        status_read <= 1'b1;
        @(posedge clk);
        status_read <= 1'b0;
        @(negedge clk);
    endtask
    task automatic do_cmd(input logic [7:0] md, input logic [7:0] pl,
                          input logic [63:0] pay, input logic bad);
        logic [7:0] blk [34];
        int n;
        int t;
        n = md[3] ? 1 : int'(pl) + 2;
        blk[0] = md;
        blk[1] = pl;
        for (int k = 0; k < 8; k++) begin
            blk[k + 2] = pay[63 - 8 * k -: 8];
        end
        @(posedge clk);
        lock_cmd <= 1'b1;
        block_len <= 10'(n);
        @(posedge clk);
        lock_cmd <= 1'b0;
        i_host.send(blk, n, bad);
        t = 0;
        while (lock_busy !== 1'b0 && t < 100) begin
            @(negedge clk);
            t++;
        end
        if (t == 100) begin
            num_errors++;
            give_verdict();
        end
    endtask
    initial begin
        srst = 1'b1;
        {lock_cmd, cmd_received, cmd_crc_bad, cmd_illegal} = '0;
        {status_read, data_access_req, ev, block_len} = '0;
        {nv_len_in, nv_secret_in, crc_seen, erase_seen} = '0;
        reset_dut();
        foreach (rows[r]) begin
            do_cmd(rows[r].md, rows[r].pl, rows[r].pay, 1'b0);
            chk(32'(locked_flag), 32'(rows[r].lk));
            chk(32'(card_status_word[24]), 32'(rows[r].fl));
            chk(32'(nv_len_out), 32'(rows[r].ln));
            pulse_read();
            chk(32'(card_status_word[24]), 32'h0);
            $display("row %0d ended", r);
        end
        chk(32'(erase_seen), 32'h1);
        do_cmd(8'h01, 8'h02, PW_OK, 1'b0);
        reset_dut();
        chk({30'h0, locked_flag, data_access_ok}, 32'h2);
        @(posedge clk);
        data_access_req <= 1'b1;
        @(posedge clk);
        data_access_req <= 1'b0;
        @(negedge clk);
        chk(32'(card_status_word[24]), 32'h1);
        pulse_read();
        do_cmd(8'h00, 8'h02, PW_OK, 1'b1);
        @(negedge clk);
        chk({30'h0, crc_seen, locked_flag}, 32'h3);
        do_cmd(8'h00, 8'h02, PW_OK, 1'b0);
        chk({30'h0, locked_flag, data_access_ok}, 32'h1);
        reset_dut();
        chk(32'(locked_flag), 32'h1);
        $display("power session test ended");
        @(posedge clk);
        lock_cmd <= 1'b1;
        block_len <= 10'h000;
        @(posedge clk);
        lock_cmd <= 1'b0;
        @(negedge clk);
        chk(32'(card_status_word[29:24]), 32'h22);
        pulse_read();
        @(posedge clk);
        ev <= 9'h1ff;
        @(posedge clk);
        ev <= 9'h000;
        @(negedge clk);
        chk(card_status_word, 32'hfe38_0000);
        pulse_read();
        chk(card_status_word, 32'h0200_0000);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            {cmd_received, cmd_crc_bad, cmd_illegal} <= {1'b1, k == 0, k == 1};
            @(posedge clk);
            cmd_received <= 1'b0;
            @(negedge clk);
            chk(32'(card_status_word[23:22]), k == 0 ? 32'h2 : 32'h1);
        end
        $display("status test ended");
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule
